/* core/art_pkg.sv */
package art_pkg;
  // register addresses
  localparam logic [7:0] ART_ADDR_RDSEL = 8'h89;
  localparam logic [7:0] ART_ADDR_IEN   = 8'hA8;
  localparam logic [7:0] ART_ADDR_CTRL  = 8'hC0;
  localparam logic [7:0] ART_ADDR_LOW   = 8'hCE;
  localparam logic [7:0] ART_ADDR_HIGH  = 8'hCF;
  localparam logic [7:0] ART_ADDR_SIBC  = 8'hC8;
  // field positions
  localparam int ART_CTRL_OVF_BIT  = 7;
  localparam int ART_CTRL_PS_HI    = 5;
  localparam int ART_CTRL_PS_LO    = 4;
  localparam int ART_CTRL_RUN_BIT  = 1;
  localparam int ART_RDSEL_BIT     = 1;
  localparam int ART_IEN_OVF_BIT   = 1;
  localparam int ART_IEN_GLOBAL    = 7;
  localparam int ART_SIBC_CLKS_BIT = 0;
  // writable masks and reset values
  localparam logic [7:0]  ART_CTRL_MASK  = 8'hB2;
  localparam logic [7:0]  ART_RDSEL_MASK = 8'h03;
  localparam logic [7:0]  ART_IEN_MASK   = 8'hF7;
  localparam logic [7:0]  ART_RST8       = 8'h00;
  localparam logic [15:0] ART_RST16      = 16'h0000;
  localparam logic [15:0] ART_CNT_MAX    = 16'hFFFF;
  // prescale division terminal counts
  localparam logic [7:0] ART_DIV1   = 8'h00;
  localparam logic [7:0] ART_DIV8   = 8'h07;
  localparam logic [7:0] ART_DIV64  = 8'h3F;
  localparam logic [7:0] ART_DIV256 = 8'hFF;
endpackage : art_pkg

/* core/art_if.sv */
`timescale 1ns/1ps
`default_nettype none
// tick from prescaler to counter core
interface art_tick_if;
  logic       tick;
  logic [1:0] div_sel;
  logic       ext_sel;
  modport pre (output tick, input div_sel, input ext_sel);
  modport core (input tick, output div_sel, output ext_sel);
endinterface : art_tick_if
`default_nettype wire

/* core/art_prescale.sv */
`timescale 1ns/1ps
`default_nettype none
module art_prescale
  import art_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // external count source, already synchronous
  input wire logic ext_pin,
  // run enable
  input wire logic run,
  // tick link
  art_tick_if.pre  tk
);
  logic       pin_d_r;   // previous pin level
  logic [7:0] div_cnt_r; // divider count
  logic       tick_r;    // registered tick
  wire        fall_edge;
  wire        src_ev;
  wire [7:0]  term;

  assign fall_edge = pin_d_r & ~ext_pin;
  assign src_ev = tk.ext_sel ? fall_edge : 1'b1;
  assign term = (tk.div_sel == 2'b00) ? ART_DIV1 :
                (tk.div_sel == 2'b01) ? ART_DIV8 :
                (tk.div_sel == 2'b10) ? ART_DIV64 : ART_DIV256;
  assign tk.tick = tick_r;

  // edge detect and divide
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_d_r   <= 1'b0;
      div_cnt_r <= ART_RST8;
      tick_r    <= 1'b0;
    end
    else
    begin
      pin_d_r <= ext_pin;
      tick_r  <= 1'b0;
      if (!run)
        div_cnt_r <= ART_RST8;
      else if (src_ev)
      begin
        if (div_cnt_r >= term)
        begin
          div_cnt_r <= ART_RST8;
          tick_r    <= 1'b1;
        end
        else
          div_cnt_r <= div_cnt_r + 8'h01;
      end
    end
  end
endmodule : art_prescale
`default_nettype wire

/* core/art_timer.sv */
// Contract
// - 16-bit up-counter counts prescaled ticks while running
// - data writes hit load, reads show count or load
// - wrap sets flag and reloads count
// - high-byte write reloads count immediately
// - overflow raises request when enabled
// - run bit never clears the count
// - clock source from sibling control bit
// - source one counts pin falls, zero sysclk
// - prescale 1, 8, 64, 256
// - flag bit7, hardware set, software writable
// - flag cleared on interrupt vector
// - run bit1 stops or counts
// - read-select bit picks count or load
// - enable bit1 masks timer request
// - global bit7 gates all requests
// - all registers reset to zero
`timescale 1ns/1ps
`default_nettype none
module art_timer
  import art_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output var  logic [7:0] rdata,
  // sibling clock-source bit and pin
  input  wire logic       clock_source_select,
  input  wire logic       external_count_pin,
  // interrupt vector acknowledge
  input  wire logic       irq_ack,
  // interrupt request and status
  output var  logic       irq,
  output var  logic       overflow_pulse
);
  // tick link between prescaler and counter core
  art_tick_if tk ();

  // software-visible registers
  logic [7:0]  ctrl_r;        // timer_control
  logic [7:0]  ctrl_nxt;      // next timer_control
  logic [7:0]  rdsel_r;       // read_source_select
  logic [7:0]  rdsel_nxt;     // next read_source_select
  logic [7:0]  ien_r;         // primary_interrupt_enable
  logic [7:0]  ien_nxt;       // next primary_interrupt_enable

  // counting state
  logic [15:0] count_r;       // live counter
  logic [15:0] count_nxt;     // next counter value
  logic [15:0] load_r;        // load register
  logic [15:0] load_nxt;      // next load register

  // byte pairing state
  logic [7:0]  low_buf_r;     // pending low write
  logic [7:0]  low_buf_nxt;   // next pending low write
  logic [7:0]  low_snap_r;    // low byte caught on high read
  logic [7:0]  low_snap_nxt;  // next low snapshot

  // output registers
  logic [7:0]  rdata_r;       // read data register
  logic [7:0]  rdata_nxt;     // next read data
  logic        irq_r;         // request output
  logic        irq_nxt;       // next request
  logic        ovf_pulse_r;   // overflow strobe
  logic        ovf_pulse_nxt; // next overflow strobe

  // address match, shared by write and read decode
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] r);
    return (a == r);
  endfunction : addr_is

  // keep only the implemented bits of a byte
  function automatic logic [7:0] keep_bits(input logic [7:0] v, input logic [7:0] m);
    return (v & m);
  endfunction : keep_bits

  // write strobes, one per register
  wire wr_ctrl;   // timer_control write
  wire wr_rdsel;  // read_source_select write
  wire wr_ien;    // primary_interrupt_enable write
  wire wr_low;    // count_low_byte write
  wire wr_high;   // count_high_byte write
  assign wr_ctrl  = wr && addr_is(addr, ART_ADDR_CTRL);
  assign wr_rdsel = wr && addr_is(addr, ART_ADDR_RDSEL);
  assign wr_ien   = wr && addr_is(addr, ART_ADDR_IEN);
  assign wr_low   = wr && addr_is(addr, ART_ADDR_LOW);
  assign wr_high  = wr && addr_is(addr, ART_ADDR_HIGH);

  // read strobes, one per register
  wire rd_ctrl;   // timer_control read
  wire rd_rdsel;  // read_source_select read
  wire rd_ien;    // primary_interrupt_enable read
  wire rd_low;    // count_low_byte read
  wire rd_high;   // count_high_byte read
  assign rd_ctrl  = rd && addr_is(addr, ART_ADDR_CTRL);
  assign rd_rdsel = rd && addr_is(addr, ART_ADDR_RDSEL);
  assign rd_ien   = rd && addr_is(addr, ART_ADDR_IEN);
  assign rd_low   = rd && addr_is(addr, ART_ADDR_LOW);
  assign rd_high  = rd && addr_is(addr, ART_ADDR_HIGH);

  // named control and enable fields
  wire run;       // run_bit
  wire flag;      // overflow_flag
  wire rd_load;   // read_source_bit
  wire ovf_en;    // overflow_irq_enable
  wire glb_en;    // global_irq_enable
  assign run     = ctrl_r[ART_CTRL_RUN_BIT];
  // flag lives in control bit 7
  assign flag    = ctrl_r[ART_CTRL_OVF_BIT];
  assign rd_load = rdsel_r[ART_RDSEL_BIT];
  assign ovf_en  = ien_r[ART_IEN_OVF_BIT];
  assign glb_en  = ien_r[ART_IEN_GLOBAL];

  // counting events
  wire        step;       // one prescaled tick while running
  wire        wrap;       // step taken at all-ones
  wire [16:0] count_sum;  // increment with carry kept
  wire [15:0] count_inc;  // increment, carry dropped on purpose
  // count step on tick while running
  assign step      = run && tk.tick;
  assign wrap      = step && (count_r == ART_CNT_MAX);
  assign count_sum = {1'b0, count_r} + 17'h00001;
  // the carry is the wrap, which the reload path handles
  assign count_inc = count_sum[15:0];

  // byte pairing values
  wire [15:0] load_new;  // high write plus buffered low
  wire [15:0] rd_src;    // word that data reads show
  // both bytes commit on high write
  assign load_new = {wdata, low_buf_r};
  assign rd_src   = rd_load ? load_r : count_r;

  assign tk.ext_sel = clock_source_select;
  assign tk.div_sel = ctrl_r[ART_CTRL_PS_HI:ART_CTRL_PS_LO];

  // prescaler and pin edge detect
  // stopping clears the divider phase, so a restart
  // waits a full prescale period before the first step
  art_prescale u_pre (
    .clk     (clk),
    .rst     (rst),
    .ext_pin (external_count_pin),
    .run     (run),
    .tk      (tk)
  );

  // readback bytes, reserved bits forced to zero
  wire [7:0] rb_ctrl;   // control readback
  wire [7:0] rb_rdsel;  // read-select readback
  wire [7:0] rb_ien;    // enable readback
  wire [7:0] rd_value;  // selected byte, zero if unmapped
  assign rb_ctrl  = keep_bits(ctrl_r, ART_CTRL_MASK);
  assign rb_rdsel = keep_bits(rdsel_r, ART_RDSEL_MASK);
  assign rb_ien   = keep_bits(ien_r, ART_IEN_MASK);
  // unmapped or idle cycles select zero
  // low read returns the snapshot
  assign rd_value = rd_ctrl  ? rb_ctrl      :
                    rd_rdsel ? rb_rdsel     :
                    rd_ien   ? rb_ien       :
                    rd_low   ? low_snap_r   :
                    rd_high  ? rd_src[15:8] : ART_RST8;

  // next values of the plain registers
  // read data stand one cycle, zero otherwise
  assign rdata_nxt     = rd_value;
  assign rdsel_nxt     = wr_rdsel ? keep_bits(wdata, ART_RDSEL_MASK) : rdsel_r;
  assign ien_nxt       = wr_ien ? keep_bits(wdata, ART_IEN_MASK) : ien_r;
  // low write waits in the buffer
  assign low_buf_nxt   = wr_low ? wdata : low_buf_r;
  // high write lands in load, and count takes the same value
  assign load_nxt      = wr_high ? load_new : load_r;
  // high read catches matching low byte
  assign low_snap_nxt  = rd_high ? rd_src[7:0] : low_snap_r;
  // gated request from flag
  // the vector cycle drops the request at once
  assign irq_nxt       = flag && ovf_en && glb_en && !irq_ack;
  // one-cycle strobe per wrap
  assign ovf_pulse_nxt = wrap;

  // next counter value
  // a high write in the wrap cycle wins, since the
  // software value is newer than the stored reload
  always_comb
  begin
    count_nxt = count_r;
    if (wr_high)
      count_nxt = load_new;
    else if (wrap)
      count_nxt = load_r;
    else if (step)
      count_nxt = count_inc;
  end

  // next control value, flag handling
  // order matters: write, then ack clear, then set,
  // so an overflow is never lost to a clear
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    // run and prescale written by software
    if (wr_ctrl)
      ctrl_nxt = keep_bits(wdata, ART_CTRL_MASK);
    if (irq_ack)
      ctrl_nxt[ART_CTRL_OVF_BIT] = 1'b0;
    if (wrap)
      ctrl_nxt[ART_CTRL_OVF_BIT] = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    // every reset source alike
    if (rst)
      ctrl_r <= ART_RST8;
    // software, flag and ack updates
    else
      ctrl_r <= ctrl_nxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    // count is shown after reset
    if (rst)
      rdsel_r <= ART_RST8;
    // software writes only
    else
      rdsel_r <= rdsel_nxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    // all requests masked after reset
    if (rst)
      ien_r <= ART_RST8;
    // software writes only
    else
      ien_r <= ien_nxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    // counter starts from zero
    if (rst)
      count_r <= ART_RST16;
    // step, wrap reload or high write
    else
      count_r <= count_nxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    // reload value cleared
    if (rst)
      load_r <= ART_RST16;
    // committed on high writes
    else
      load_r <= load_nxt;
  end

  // low write buffer
  always_ff @(posedge clk or posedge rst)
  begin
    // nothing pending after reset
    if (rst)
      low_buf_r <= ART_RST8;
    // held until the high write
    else
      low_buf_r <= low_buf_nxt;
  end

  // low byte snapshot
  always_ff @(posedge clk or posedge rst)
  begin
    // low reads show zero until a high read
    if (rst)
      low_snap_r <= ART_RST8;
    // refreshed on every high read
    else
      low_snap_r <= low_snap_nxt;
  end

  // read data register
  always_ff @(posedge clk or posedge rst)
  begin
    // bus reads zero in reset
    if (rst)
      rdata_r <= ART_RST8;
    // byte of the previous cycle's read
    else
      rdata_r <= rdata_nxt;
  end

  // interrupt request register
  always_ff @(posedge clk or posedge rst)
  begin
    // no request in reset
    if (rst)
      irq_r <= 1'b0;
    // gated flag level
    else
      irq_r <= irq_nxt;
  end

  // overflow strobe register
  always_ff @(posedge clk or posedge rst)
  begin
    // quiet in reset
    if (rst)
      ovf_pulse_r <= 1'b0;
    // high the cycle after each wrap
    else
      ovf_pulse_r <= ovf_pulse_nxt;
  end

  // outputs straight from their flip-flops
  assign rdata          = rdata_r;
  assign irq            = irq_r;
  assign overflow_pulse = ovf_pulse_r;
endmodule : art_timer
`default_nettype wire

/* test/art_timer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module art_timer_sva
  import art_pkg::*;
(
  // clock and bus
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // pins and interrupt
  input wire logic       clock_source_select,
  input wire logic       external_count_pin,
  input wire logic       irq_ack,
  input wire logic       irq,
  input wire logic       overflow_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // shadows of enable and control writes
  logic [7:0] ien_r;
  logic [7:0] ctl_r;
  wire        en  = ien_r[ART_IEN_OVF_BIT] & ien_r[ART_IEN_GLOBAL];
  wire        hit = addr inside {ART_ADDR_RDSEL, ART_ADDR_IEN, ART_ADDR_CTRL,
                                 ART_ADDR_LOW, ART_ADDR_HIGH};
  always_ff @(posedge clk or posedge rst)
    if (rst)
      ien_r <= ART_RST8;
    else if (wr && addr == ART_ADDR_IEN)
      ien_r <= wdata;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      ctl_r <= ART_RST8;
    else if (wr && addr == ART_ADDR_CTRL)
      ctl_r <= wdata;
  rd_idle_a: assert property (!rd |=> rdata == ART_RST8)
    else $error("rdata not zero when idle");
  rd_unmap_a: assert property (rd && !hit |=> rdata == ART_RST8)
    else $error("unmapped read not zero");
  rsv_bits_a: assert property (rd && addr == ART_ADDR_CTRL |=> (rdata & ~ART_CTRL_MASK) == 0)
    else $error("reserved control bits set");
  irq_gate_a: assert property (irq |-> en || $past(en))
    else $error("irq while masked");
  irq_rise_a: assert property (overflow_pulse && en && !irq_ack |-> ##[0:2] irq)
    else $error("irq missing after wrap");
  ack_clear_a: assert property (irq_ack |=> !irq)
    else $error("irq kept after ack");
  stop_hold_a: assert property (!ctl_r[ART_CTRL_RUN_BIT] [*6] |-> !overflow_pulse)
    else $error("wrap while stopped");
  reset_out_a: assert property ($fell(rst) |-> !irq && !overflow_pulse && rdata == 0)
    else $error("outputs not clear after reset");
  cover property (overflow_pulse && en);
  cover property (irq_ack && irq);
  cover property (rd && !hit);
endmodule : art_timer_sva
bind art_timer art_timer_sva u_sva (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .clock_source_select(clock_source_select),
  .external_count_pin(external_count_pin), .irq_ack(irq_ack), .irq(irq),
  .overflow_pulse(overflow_pulse));
`default_nettype wire

/* test/tb_auto_reload_timer_sixteen_bit.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_auto_reload_timer_sixteen_bit
  import art_pkg::*;
();
  typedef struct packed {logic w; logic [7:0] a, d, e;} art_row_s;
  logic clk = 0, rst = 1, wr = 0, rd = 0, cs = 0, pin = 1, ack = 0, tog = 0;
  logic [7:0] addr = 0, wd = 0, g;
  logic [15:0] v;
  wire [7:0] rdata;
  wire irq, op;
  int fails = 0, n_checks = 0, n;
  int gap [5] = '{1, 8, 64, 256, 2};
  // reset values, masks, unmapped place
  art_row_s rows [12] = '{'{0, 8'h89, 0, 0}, '{0, 8'hA8, 0, 0}, '{0, 8'hC0, 0, 0},
    '{0, 8'hCE, 0, 0}, '{0, 8'hCF, 0, 0}, '{1, 8'hC0, 8'hFD, 8'hB0}, '{1, 8'hC0, 0, 0},
    '{1, 8'h89, 8'hFF, 8'h03}, '{1, 8'h89, 0, 0}, '{1, 8'hA8, 8'hFF, 8'hF7},
    '{1, 8'hA8, 0, 0}, '{1, 8'h10, 8'hFF, 0}};
  art_timer DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wd), .wr(wr), .rd(rd),
    .rdata(rdata), .clock_source_select(cs), .external_count_pin(pin),
    .irq_ack(ack), .irq(irq), .overflow_pulse(op));
  initial forever #2 clk = ~clk;
  // pin toggles each cycle when enabled
  always @(posedge clk) if (tog) pin <= ~pin;
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(posedge clk);
    q = rdata;
  endtask : rd_reg
  // high byte first, low byte from snapshot
  task rd16(input logic [15:0] e);
    rd_reg(ART_ADDR_HIGH, v[15:8]);
    rd_reg(ART_ADDR_LOW, v[7:0]);
    chk(v, e);
  endtask : rd16
  // edges up to the next overflow pulse
  task wait_p(output int k);
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (op !== 1'b1 && k < 600);
    if (op !== 1'b1)
    begin
      fails++;
      test_done();
    end
  endtask : wait_p
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 0;
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, g);
      chk({8'h00, g}, {8'h00, rows[i].e});
    end
    wr_reg(ART_ADDR_LOW, 8'h34);
    wr_reg(ART_ADDR_HIGH, 8'h12);
    wr_reg(ART_ADDR_LOW, 8'h56);
    rd16(16'h1234);
    wr_reg(ART_ADDR_RDSEL, 8'h02);
    rd16(16'h1234);
    wr_reg(ART_ADDR_HIGH, 8'hAB);
    rd16(16'hAB56);
    wr_reg(ART_ADDR_RDSEL, 8'h00);
    wr_reg(ART_ADDR_CTRL, 8'h32);
    rd_reg(ART_ADDR_HIGH, g);
    chk({8'h00, g}, 16'h00AB);
    wr_reg(ART_ADDR_IEN, 8'h82);
    // all-ones reload wraps on every tick
    for (int i = 0; i < 5; i++)
    begin
      cs <= (i == 4);
      tog <= (i == 4);
      wr_reg(ART_ADDR_LOW, 8'hFF);
      wr_reg(ART_ADDR_HIGH, 8'hFF);
      wr_reg(ART_ADDR_CTRL, {2'b00, i[1:0] & {2{i < 4}}, 4'h2});
      wait_p(n);
      wait_p(n);
      chk(n[15:0], gap[i][15:0]);
      rd_reg(ART_ADDR_CTRL, g);
      chk({8'h00, g}, {8'h00, 2'b10, i[1:0] & {2{i < 4}}, 4'h2});
      wr_reg(ART_ADDR_CTRL, 8'h80);
    end
    tog <= 0;
    repeat (8) @(posedge clk);
    chk({15'h0, irq}, 16'h0001);
    wr_reg(ART_ADDR_IEN, 8'h02);
    repeat (3) @(posedge clk);
    chk({15'h0, irq}, 16'h0000);
    wr_reg(ART_ADDR_IEN, 8'h82);
    @(posedge clk);
    ack <= 1;
    @(posedge clk);
    ack <= 0;
    repeat (2) @(posedge clk);
    chk({15'h0, irq}, 16'h0000);
    rd_reg(ART_ADDR_CTRL, g);
    chk({8'h00, g}, 16'h0000);
    // software sets the flag, then reset lands mid-run
    wr_reg(ART_ADDR_IEN, 8'h82);
    wr_reg(ART_ADDR_CTRL, 8'h82);
    repeat (2) @(posedge clk);
    chk({15'h0, irq}, 16'h0001);
    rst <= 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    chk({15'h0, irq}, 16'h0000);
    rd_reg(ART_ADDR_CTRL, g);
    chk({8'h00, g}, 16'h0000);
    rd_reg(ART_ADDR_IEN, g);
    chk({8'h00, g}, 16'h0000);
    rd16(16'h0000);
    test_done();
  end
endmodule : tb_auto_reload_timer_sixteen_bit
`default_nettype wire
